// ===== hdl/pmc_carry_tree.sv
// two-level AND tree producing the toggle enables
`timescale 1ns/100ps
`include "pmc_map.svh"
module pmc_carry_tree import pmc_pkg::*; #(
  parameter int W = `PMC_WIDTH
) (
  input  wire logic [W-1:0] bits, // direction-adjusted count bits
  output wire logic [W-1:0] tgl   // toggle enable per bit
);
  localparam int GRP = `PMC_GROUP;
  localparam int NG  = W / GRP;

  logic [NG-1:0] gp;

  genvar g, i;
  // first level: propagate of each full group
  for (g = 0; g < NG; g++) begin : g_grp
    assign gp[g] = &bits[g*GRP +: GRP];
  end

  // second level: groups below AND partial group below
  for (i = 0; i < W; i++) begin : g_bit
    localparam int G = i / GRP;
    localparam int R = i % GRP;
    logic lo;
    logic hi;
    if (R == 0) begin : g_lo0
      assign lo = 1'b1;
    end else begin : g_lo
      assign lo = &bits[G*GRP +: R];
    end
    if (G == 0) begin : g_hi0
      assign hi = 1'b1;
    end else begin : g_hi
      assign hi = &gp[G-1:0];
    end
    assign tgl[i] = lo & hi;
  end
endmodule : pmc_carry_tree

// ===== hdl/pmc_counter.sv
// presettable modulo counter with pipelined terminal count
`timescale 1ns/100ps
`include "pmc_map.svh"
module pmc_counter import pmc_pkg::*; #(
  parameter int       WIDTH = `PMC_WIDTH,
  parameter pmc_dir_t DIR   = PMC_UP
) (
  input  wire logic             ref_clk,          // 25 MHz clock
  input  wire logic             rst,              // sync reset
  input  wire logic             flag_rst,         // async flag reset
  input  wire pmc_ctl_t         ctl,              // enable and load
  input  wire logic [WIDTH-1:0] load_val,         // parallel input
  output logic      [WIDTH-1:0] count_q,          // count value
  output logic                  final_state_flag, // terminal state
  output logic                  par_en_n          // parallel enable
);
  localparam logic [WIDTH-1:0] ONES = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ZERO = {WIDTH{1'b0}};
  localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};
  localparam logic [WIDTH-1:0] PRE  = ONES ^ ONE;

  // up sees the bits as they are, down sees them inverted
  function automatic logic [WIDTH-1:0] dir_view(
    input logic [WIDTH-1:0] v
  );
    return (DIR == PMC_DOWN) ? ~v : v;
  endfunction : dir_view

  logic             pe_n_reg;
  logic             pe_n_next;
  logic             fsf_reg;
  logic             fsf_next;
  logic             load_now;
  logic             cell_clock_gate;
  logic             pre_tc;
  logic [WIDTH-1:0] view;
  logic [WIDTH-1:0] tgl;

  // the flag flop output and the load command act on the load at once
  assign load_now = (pe_n_reg == `PMC_PEN_ON) | ctl.load_cmd;

  // loads pass even while counting is disabled
  assign cell_clock_gate = ctl.count_en | load_now;

  assign view   = dir_view(count_q);
  assign pre_tc = (view == PRE);

  pmc_carry_tree #(
    .W (WIDTH)
  ) u_tree (
    .bits (view),
    .tgl  (tgl)
  );

  pmc_tff_bank #(
    .W (WIDTH)
  ) u_bank (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .cell_clock_gate (cell_clock_gate),
    .par_load        (load_now),
    .load_val        (load_val),
    .tgl             (tgl),
    .count_q         (count_q)
  );

  // flag input: pre-terminal decode gated by the parallel enable
  always_comb begin
    pe_n_next = pe_n_reg;
    if (cell_clock_gate) begin
      if (pre_tc && !load_now) begin
        pe_n_next = `PMC_PEN_ON;
      end else begin
        pe_n_next = `PMC_PEN_OFF;
      end
    end
    fsf_next = ~pe_n_next;
  end

  // power-up reset asserts the parallel enable
  always_ff @(posedge ref_clk or posedge flag_rst) begin
    if (flag_rst) begin
      pe_n_reg <= `PMC_PEN_ON;
      fsf_reg  <= `PMC_FLAG_ON;
    end else if (rst) begin
      pe_n_reg <= `PMC_PEN_ON;
      fsf_reg  <= `PMC_FLAG_ON;
    end else begin
      pe_n_reg <= pe_n_next;
      fsf_reg  <= fsf_next;
    end
  end

  assign par_en_n         = pe_n_reg;
  assign final_state_flag = fsf_reg;

  // checking helpers
  logic [WIDTH-1:0] step_ref;
  logic [WIDTH-1:0] tgl_ref;
  logic             run_and;
  logic             advance;
  logic             idle;

  always_comb begin
    run_and = 1'b1;
    tgl_ref = ZERO;
    for (int k = 0; k < WIDTH; k++) begin
      tgl_ref[k] = run_and;
      run_and    = run_and & view[k];
    end
  end

  assign step_ref = (DIR == PMC_DOWN) ? WIDTH'(count_q - ONE)
                                      : WIDTH'(count_q + ONE);
  assign advance  = ctl.count_en && !load_now;
  assign idle     = !ctl.count_en && !load_now;

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (rst || flag_rst);

  sequence s_load;
    !par_en_n;
  endsequence

  sequence s_term_load;
    !par_en_n && (dir_view(load_val) == ONES);
  endsequence

  sequence s_count;
    ctl.count_en && !ctl.load_cmd;
  endsequence

  // an asserted parallel enable always loads the parallel input
  property p_load_on_pe;
    s_load |=> (count_q == $past(load_val));
  endproperty
  a_load_on_pe: assert property (p_load_on_pe)
    else $error("parallel enable did not load the input");

  // a full modulo cycle: loaded value then step count to terminal
  property p_modulo_entry;
    s_load ##1 (s_count and (par_en_n && pre_tc))
      |=> !par_en_n ##1 (count_q == $past(load_val));
  endproperty
  a_modulo_entry: assert property (p_modulo_entry)
    else $error("terminal count did not reload the input");

  // load command loads on the next edge
  property p_cmd_load;
    ctl.load_cmd |=> (count_q == $past(load_val));
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("load command did not load the input");

  // one step per enabled clock without a load
  property p_step;
    advance |=> (count_q == $past(step_ref));
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step by one");

  // toggled bits match the AND of all lower direction-adjusted bits
  property p_toggle;
    advance |=> ((count_q ^ $past(count_q)) == $past(tgl_ref));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle pattern differs from lower-bit AND");

  // tree output equals the reference chain
  property p_tree;
    tgl == tgl_ref;
  endproperty
  a_tree: assert property (p_tree)
    else $error("carry tree output is wrong");

  // disabled and not loading: nothing moves
  property p_hold;
    idle |=> $stable(count_q) && $stable(par_en_n);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while disabled");

  // a pending load is honoured while counting is disabled
  property p_load_disabled;
    (s_load and !ctl.count_en) |=> (count_q == $past(load_val));
  endproperty
  a_load_disabled: assert property (p_load_disabled)
    else $error("load lost while counting disabled");

  // pre-terminal state sets the flag for the terminal state
  property p_pre_sets;
    (pre_tc && advance) |=> !par_en_n && (view == ONES)
                            && final_state_flag;
  endproperty
  a_pre_sets: assert property (p_pre_sets)
    else $error("flag not set for terminal state");

  // flag only rises entering the terminal state
  property p_flag_state;
    $fell(par_en_n) |-> (view == ONES);
  endproperty
  a_flag_state: assert property (p_flag_state)
    else $error("flag set outside the terminal state");

  // flag output mirrors the parallel enable
  property p_flag_out;
    final_state_flag == !par_en_n;
  endproperty
  a_flag_out: assert property (p_flag_out)
    else $error("flag and parallel enable disagree");

  // never two loads in a row from the flag
  property p_no_double;
    (s_load or ctl.load_cmd) |=> par_en_n;
  endproperty
  a_no_double: assert property (p_no_double)
    else $error("parallel enable held for two clocks");

  // loading the terminal value rolls over instead of reloading
  property p_roll;
    s_term_load ##1 s_count |=> (view == ZERO) && par_en_n;
  endproperty
  a_roll: assert property (p_roll)
    else $error("terminal load did not roll over");

  // down version counts toward all zeros
  property p_down_dir;
    (DIR == PMC_DOWN) && advance && (count_q != ZERO)
      |=> (count_q < $past(count_q));
  endproperty
  a_down_dir: assert property (p_down_dir)
    else $error("down counter did not decrease");

  // flag reset holds the parallel enable; first edge after loads
  property p_flag_rst;
    @(posedge ref_clk) disable iff (rst)
      flag_rst ##1 !flag_rst |-> !par_en_n
        ##1 (count_q == $past(load_val));
  endproperty
  a_flag_rst: assert property (p_flag_rst)
    else $error("flag reset did not force a load");

  // reset clears the count and asserts the parallel enable, so the first edge loads
  property p_rst_state;
    @(posedge ref_clk) disable iff (flag_rst)
      rst |=> (count_q == ZERO) && !par_en_n;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("reset state wrong");

  sequence s_pre_cmd;
    pre_tc && ctl.load_cmd;
  endsequence

  // a command in the pre-terminal state loads once and sets no flag
  property p_pre_cmd;
    s_pre_cmd |=> par_en_n && (count_q == $past(load_val));
  endproperty
  a_pre_cmd: assert property (p_pre_cmd)
    else $error("command before terminal left the flag set");

  // a command while counting is disabled still loads
  property p_cmd_disabled;
    (ctl.load_cmd && !ctl.count_en) |=> (count_q == $past(load_val));
  endproperty
  a_cmd_disabled: assert property (p_cmd_disabled)
    else $error("command load lost while disabled");

  // a terminal-value load leaves the flag clear
  property p_roll_load;
    s_term_load |=> (view == ONES) && par_en_n;
  endproperty
  a_roll_load: assert property (p_roll_load)
    else $error("terminal value load reloaded");

  // the flag only rises after a decoded pre-terminal step
  property p_pre_decode;
    $fell(par_en_n) |-> $past(pre_tc) && $past(advance);
  endproperty
  a_pre_decode: assert property (p_pre_decode)
    else $error("flag set without pre-terminal decode");

  // up version counts toward all ones
  property p_up_dir;
    (DIR == PMC_UP) && advance && (count_q != ONES)
      |=> (count_q > $past(count_q));
  endproperty
  a_up_dir: assert property (p_up_dir)
    else $error("up counter did not increase");

  // flag reset holds the enable low at once
  property p_flag_async;
    @(posedge ref_clk) disable iff (rst)
      flag_rst |-> !par_en_n && final_state_flag;
  endproperty
  a_flag_async: assert property (p_flag_async)
    else $error("flag reset did not assert the enable");

  // every edge under flag reset loads the parallel input
  property p_flag_load;
    @(posedge ref_clk) disable iff (rst)
      flag_rst |=> (count_q == $past(load_val));
  endproperty
  a_flag_load: assert property (p_flag_load)
    else $error("flag reset edge did not load");

endmodule : pmc_counter

// ===== hdl/pmc_tff_bank.sv
// bank of loadable toggle flip-flops holding the count
`timescale 1ns/100ps
`include "pmc_map.svh"
module pmc_tff_bank import pmc_pkg::*; #(
  parameter int W = `PMC_WIDTH
) (
  input  wire logic         ref_clk,         // clock
  input  wire logic         rst,             // sync reset
  input  wire logic         cell_clock_gate, // bank clock enable
  input  wire logic         par_load,        // load instead of toggle
  input  wire logic [W-1:0] load_val,        // parallel input
  input  wire logic [W-1:0] tgl,             // toggle enables
  output logic      [W-1:0] count_q          // count flops
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (cell_clock_gate) begin
      if (par_load) begin
        cnt_next = load_val;
      end else begin
        cnt_next = cnt_reg ^ tgl;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= {W{`PMC_CNT_RST}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count_q = cnt_reg;
endmodule : pmc_tff_bank

// ===== pkg/pmc_map.svh
// constants of the presettable modulo counter
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_WIDTH   8
`define PMC_GROUP   4
`define PMC_PEN_ON  1'b0
`define PMC_PEN_OFF 1'b1
`define PMC_CNT_RST 1'b0
`define PMC_FLAG_ON 1'b1
`endif

// ===== pkg/pmc_pkg.sv
// types of the presettable modulo counter
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_UP   = 2'b01,
    PMC_DOWN = 2'b10
  } pmc_dir_t;

  typedef struct packed {
    logic count_en;
    logic load_cmd;
  } pmc_ctl_t;
endpackage : pmc_pkg

// ===== verification/pmc_user_model.sv
// user logic model that feeds the load value and the load command
`timescale 1ns/100ps
module pmc_user_model import pmc_pkg::*; #(
  parameter int       WIDTH = 8,
  parameter pmc_dir_t DIR   = PMC_UP
) (
  input  wire logic             ref_clk,   // clock
  input  wire logic [WIDTH-1:0] count_q,   // count seen by user logic
  input  wire logic             want_en,   // requested count enable
  input  wire logic             want_load, // requested load command
  input  wire logic [WIDTH-1:0] want_val,  // requested load value
  input  wire logic             allow_pre, // permit load before terminal
  output pmc_ctl_t              ctl,       // enable and load
  output logic      [WIDTH-1:0] load_val   // parallel input
);
  logic [WIDTH-1:0] pre_term;
  logic             withhold;
  assign pre_term = (DIR == PMC_UP) ? {{(WIDTH-1){1'b1}}, 1'b0}
                                    : {{(WIDTH-1){1'b0}}, 1'b1};
  // load command is withheld one step before terminal unless permitted
  assign withhold = !allow_pre && (count_q === pre_term);
  always @(negedge ref_clk) begin
    ctl.count_en <= want_en;
    ctl.load_cmd <= want_load && !withhold;
    load_val     <= want_val;
  end
endmodule : pmc_user_model

// ===== verification/tb.sv
// self-checking bench of the presettable modulo counter
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
  err_total++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb import pmc_pkg::*;;
  localparam int W = 8;
  localparam int WD = 16;
  logic         ref_clk   = 1'b0;
  logic         rst       = 1'b1;
  logic         flag_rst  = 1'b0;
  logic         want_en   = 1'b1;
  logic         want_load = 1'b0;
  logic [W-1:0] want_val  = 8'hfc;
  logic         allow_pre = 1'b0;
  pmc_ctl_t     ctl;
  logic [W-1:0] load_val;
  logic [W-1:0] count_q;
  logic         final_state_flag;
  logic         par_en_n;
  logic          dn_want_en   = 1'b0;
  logic          dn_want_load = 1'b0;
  logic [WD-1:0] dn_want_val  = 16'h0003;
  pmc_ctl_t      dn_ctl;
  logic [WD-1:0] dn_load_val;
  logic [WD-1:0] dn_count_q;
  logic          dn_flag;
  logic          dn_pen;
  int           err_total  = 0;
  int           n_compared = 0;
  int           cycles     = 0;

  pmc_counter #(.WIDTH(W), .DIR(PMC_UP)) i_pmc_counter (
    .ref_clk(ref_clk), .rst(rst), .flag_rst(flag_rst), .ctl(ctl),
    .load_val(load_val), .count_q(count_q),
    .final_state_flag(final_state_flag), .par_en_n(par_en_n));
  pmc_user_model #(.WIDTH(W), .DIR(PMC_UP)) i_pmc_user_model (
    .ref_clk(ref_clk), .count_q(count_q), .want_en(want_en),
    .want_load(want_load), .want_val(want_val), .allow_pre(allow_pre),
    .ctl(ctl), .load_val(load_val));
  // down counter at the widest supported width
  pmc_counter #(.WIDTH(WD), .DIR(PMC_DOWN)) i_pmc_counter_dn (
    .ref_clk(ref_clk), .rst(rst), .flag_rst(flag_rst), .ctl(dn_ctl),
    .load_val(dn_load_val), .count_q(dn_count_q),
    .final_state_flag(dn_flag), .par_en_n(dn_pen));
  pmc_user_model #(.WIDTH(WD), .DIR(PMC_DOWN)) i_pmc_user_model_dn (
    .ref_clk(ref_clk), .count_q(dn_count_q), .want_en(dn_want_en),
    .want_load(dn_want_load), .want_val(dn_want_val),
    .allow_pre(allow_pre), .ctl(dn_ctl), .load_val(dn_load_val));

  always #20 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // the model applies requests at the falling edge, then one edge acts
  task automatic cyc(input logic en, input logic ld, input logic [W-1:0] v);
    want_en = en;
    want_load = ld;
    want_val = v;
    @(posedge ref_clk);
    #5;
  endtask : cyc

  task automatic chk3(input logic [W-1:0] c, input logic pen);
    `CHK(count_q, c, "count value")
    `CHK(par_en_n, pen, "parallel enable")
    `CHK(final_state_flag, ~pen, "terminal flag")
  endtask : chk3

  task automatic dcyc(input logic en, input logic ld,
                      input logic [WD-1:0] v);
    dn_want_en = en;
    dn_want_load = ld;
    dn_want_val = v;
    @(posedge ref_clk);
    #5;
  endtask : dcyc

  task automatic dchk(input logic [WD-1:0] c, input logic pen);
    `CHK(dn_count_q, c, "down count value")
    `CHK(dn_pen, pen, "down parallel enable")
    `CHK(dn_flag, ~pen, "down terminal flag")
  endtask : dchk

  task automatic t_reset;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(posedge ref_clk);
    #5;
    chk3(8'hfc, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modulus;
    cyc(1'b1, 1'b0, 8'hfc);
    chk3(8'hfd, 1'b1);
    cyc(1'b1, 1'b0, 8'hfc);
    chk3(8'hfe, 1'b1);
    cyc(1'b1, 1'b0, 8'hfc);
    chk3(8'hff, 1'b0);
    cyc(1'b1, 1'b0, 8'hfc);
    chk3(8'hfc, 1'b1);
    $display("test modulus done");
  endtask : t_modulus

  task automatic t_ones;
    repeat (3) cyc(1'b1, 1'b0, 8'hff);
    chk3(8'hff, 1'b0);
    cyc(1'b0, 1'b0, 8'hff);
    chk3(8'hff, 1'b1);
    cyc(1'b1, 1'b0, 8'hff);
    chk3(8'h00, 1'b1);
    cyc(1'b0, 1'b0, 8'hff);
    chk3(8'h00, 1'b1);
    $display("test all ones done");
  endtask : t_ones

  task automatic t_anytime;
    cyc(1'b0, 1'b1, 8'h10);
    chk3(8'h10, 1'b1);
    cyc(1'b1, 1'b1, 8'h20);
    chk3(8'h20, 1'b1);
    cyc(1'b1, 1'b0, 8'h20);
    chk3(8'h21, 1'b1);
    $display("test load anytime done");
  endtask : t_anytime

  task automatic t_pre;
    cyc(1'b1, 1'b1, 8'hfd);
    cyc(1'b1, 1'b0, 8'hfd);
    chk3(8'hfe, 1'b1);
    allow_pre = 1'b1;
    cyc(1'b1, 1'b1, 8'h30);
    allow_pre = 1'b0;
    chk3(8'h30, 1'b1);
    cyc(1'b1, 1'b0, 8'h30);
    chk3(8'h31, 1'b1);
    $display("test load before terminal done");
  endtask : t_pre

  task automatic t_power;
    want_val = 8'h40;
    @(negedge ref_clk);
    flag_rst = 1'b1;
    #1;
    `CHK(par_en_n, 1'b0, "enable during flag reset")
    @(posedge ref_clk);
    #5;
    `CHK(count_q, 8'h40, "load during flag reset")
    want_val = 8'h50;
    @(negedge ref_clk);
    flag_rst = 1'b0;
    @(posedge ref_clk);
    #5;
    chk3(8'h50, 1'b1);
    cyc(1'b1, 1'b0, 8'h50);
    chk3(8'h51, 1'b1);
    $display("test flag reset done");
  endtask : t_power

  task automatic t_down;
    dcyc(1'b1, 1'b0, 16'h0003);
    dchk(16'h0002, 1'b1);
    dcyc(1'b1, 1'b0, 16'h0000);
    dchk(16'h0001, 1'b1);
    dcyc(1'b1, 1'b0, 16'h0000);
    dchk(16'h0000, 1'b0);
    dcyc(1'b1, 1'b0, 16'h0000);
    dchk(16'h0000, 1'b1);
    dcyc(1'b1, 1'b0, 16'h0000);
    dchk(16'hffff, 1'b1);
    dcyc(1'b1, 1'b1, 16'h0001);
    dchk(16'h0001, 1'b1);
    dcyc(1'b1, 1'b1, 16'h0001);
    dchk(16'h0000, 1'b0);
    dcyc(1'b1, 1'b0, 16'h0001);
    dchk(16'h0001, 1'b1);
    repeat (3) dcyc(1'b1, 1'b0, 16'h0001);
    dchk(16'h0000, 1'b0);
    $display("test down counter done");
  endtask : t_down

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 500) begin
      err_total++;
      give_verdict;
    end
  end

  initial begin
    t_reset;
    t_modulus;
    t_ones;
    t_anytime;
    t_pre;
    t_power;
    t_down;
    give_verdict;
  end
endmodule : tb
